// *** design/usc_defs.svh ***
// Purpose: Named offsets, bit positions, reset values and counts of the serial control block
// Assumes: Included by bare name; definitions only
// Notes:   Register indices times four give the Avalon byte address
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH
// Register indices
`define USC_IDX_DATA    8'hb8
`define USC_IDX_BAUD    8'hb9
`define USC_IDX_CTRL    8'hba
`define USC_IDX_RSTAT   8'hbb
`define USC_IDX_IRQCLK  8'hbc
// serial_control_status bits
`define USC_C_PEN       7
`define USC_C_PKHI      6
`define USC_C_X9        5
`define USC_C_CHHI      4
`define USC_C_CHLO      3
`define USC_C_ERR       2
`define USC_C_RXF       1
`define USC_C_TXE       0
// serial_receive_status bits
`define USC_S_OVR       7
`define USC_S_FRM       6
`define USC_S_PAR       5
`define USC_S_BRK       4
`define USC_S_R9        3
`define USC_S_ADDRESS_WAIT_MODE      2
`define USC_S_ACT       1
`define USC_S_LF        0
// serial_irq_clock_source bits
`define USC_I_TWO_STOP_SELECT      7
`define USC_I_BRK       6
`define USC_I_TXEN      5
`define USC_I_SYNC      4
`define USC_I_XR        3
`define USC_I_XT        2
`define USC_I_ERI       1
`define USC_I_ETI       0
// Write masks and reset values
`define USC_IRQCLK_WMASK 8'hef
`define USC_REG_RST      8'h00
`define USC_CTRL_RW_RST  5'h00
`define USC_TXE_RST      1'b1
`define USC_RD_PAD       24'h000000
// Oversampling: sixteen ticks per bit, samples around the centre
`define USC_OVS_LAST    4'hf
`define USC_MID_A       4'h7
`define USC_MID_B       4'h8
`define USC_MID_C       4'h9
// Data bit counts and encodings
`define USC_N7          4'h7
`define USC_N8          4'h8
`define USC_N9          4'h9
`define USC_CH_8        2'b00
`define USC_CH_7        2'b01
`define USC_CH_LOOP     2'b11
`define USC_PK_ODD      2'b00
`define USC_PK_EVEN     2'b01
`define USC_PK_MARK     2'b10
`endif

// *** design/usc_pkg.sv ***
// Purpose: Types shared by the serial control block
// Assumes: Constants live in usc_defs.svh
// Notes:   State encodings are left to the tools
package usc_pkg;
  typedef enum logic [2:0] {USC_TX_IDLE, USC_TX_START, USC_TX_DATA, USC_TX_PAR, USC_TX_STOP} usc_tx_state_t;
  typedef enum logic [2:0] {USC_RX_IDLE, USC_RX_START, USC_RX_DATA, USC_RX_PAR, USC_RX_STOP} usc_rx_state_t;
endpackage

// *** design/usc_clk_sel.sv ***
// Purpose: Selects internal or pin clock level and turns its edges into one-cycle enables
// Assumes: Pin level is synchronous to clk_i
// Notes:   Changing the select mid-frame may give one spurious edge
`timescale 1ns/10ps
module usc_clk_sel (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ext_sel_i,
  input  wire logic int_lvl_i,
  input  wire logic pin_lvl_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic lvl;
  logic prev_r;

  // Source chosen by the clock select bit
  assign lvl = ext_sel_i ? pin_lvl_i : int_lvl_i;

  // Previous level for edge detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  assign rise_o = lvl & ~prev_r;
  assign fall_o = ~lvl & prev_r;
endmodule

// *** design/usc_regs.sv ***
// Purpose: Control, status and framing logic of a full-duplex serial transceiver
// Assumes: Avalon-MM slave with waitrequest, byte address, pins synchronous to clk_i
// Notes:   Registers sit at index times four; bits above 7 read as zero
// Contract
// - Parity only when enabled, 7/8-bit frames
// - Parity kinds odd, even, one, zero
// - Shared bit: ninth bit or parity select
// - Length field selects eight, seven, nine bits
// - Global fault set by any receive error
// - Receive full set on load, cleared by read
// - Transmit empty set on transfer, cleared write
// - Error flags sticky, cleared by status read
// - Received ninth bit stored, read-only
// - Attention mode cleared by ninth bit one
// - Transmit active until last stop ends
// - Line fault set on framing or break, cleared high
// - One or two transmitted stop bits
// - Break holds transmit pin low
// - Mode bit selects async or sync, read-only
// - Receiver clock internal or from pin
// - Transmitter clock internal or from pin
// - Separate receive and transmit interrupt enables
// - Receive pin connected except in loopback
// - Clock pin outputs baud clock or clocks
// - Async sixteen ticks per bit, sync one
// - Start confirmed at half bit, triple sampling
// - Interrupts pending while flag and enable set
// - Sync launches on rise, captures on fall
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "usc_defs.svh"
module usc_regs
  import usc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        receive_pin_i,
  output logic             transmit_pin_o,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_n_o,
  input  wire logic        clock_port_dir_out_i,
  input  wire logic        sync_mode_strap_i,
  output logic             rx_irq_o,
  output logic             tx_irq_o
);
  logic          wait_r, strap_done_r, sync_r, address_wait_mode_r, rx9_r, tx_empty_r, rx_full_r;
  logic          ovr_r, frm_r, par_r, brk_r, lfault_r, tx_line_r, tx_pin_r, baud_lvl_r, oe_n_r;
  logic          tx_irq_r, rx_irq_r, tx_empty_nxt, rx_full_nxt, maj_r, zero_r, rx_par_r;
  logic [31:0]   rdata_r;
  logic [7:3]    ctrl_rw_r;
  logic [7:0]    irq_rw_r, baud_r, baud_cnt_r, tx_hold_r, rx_hold_r, rd_mux, rstat;
  logic [8:0]    tx_shift_r, rx_shift_r;
  logic [3:0]    tx_cnt_r, tx_idx_r, rx_cnt_r, rx_idx_r, nbits, last_idx;
  logic [1:0]    char_len, s_r;
  logic [7:0]    idx;
  usc_tx_state_t tx_state_r;
  usc_rx_state_t rx_state_r;
  logic          take, wr_ok, rd_ok, wr_data, wr_ctrl, wr_rstat, wr_irq, wr_baud, rd_data, rd_rstat;
  logic          nine_bits, par_on, loop_on, tx_par, fault_any;
  logic          tx_tick, tx_done, stop_end, tx_load, rx_rise, rx_fall, rx_tick, rx_done, rx_in, rx_val;
  logic          frame_done, frm_set, brk_set, par_set, ovr_set, rx_accept, rx_load;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Parity of seven or eight data bits for the selected kind
  function automatic logic usc_parity(input logic [7:0] d, input logic seven, input logic [1:0] kind);
    logic x;
    x = seven ? ^d[6:0] : ^d;
    case (kind)
      `USC_PK_ODD:  usc_parity = ~x;
      `USC_PK_EVEN: usc_parity = x;
      `USC_PK_MARK: usc_parity = 1'b1;
      default:      usc_parity = 1'b0;
    endcase
  endfunction

  // Bus decode; an access completes one cycle after it is taken
  assign idx      = avs_address_i[9:2];
  assign take     = (avs_read_i | avs_write_i) & wait_r;
  assign wr_ok    = avs_write_i & ~wait_r & avs_byteenable_i[0];
  assign rd_ok    = avs_read_i & ~wait_r;
  assign wr_data  = wr_ok & (idx == `USC_IDX_DATA);
  assign wr_baud  = wr_ok & (idx == `USC_IDX_BAUD);
  assign wr_ctrl  = wr_ok & (idx == `USC_IDX_CTRL);
  assign wr_rstat = wr_ok & (idx == `USC_IDX_RSTAT);
  assign wr_irq   = wr_ok & (idx == `USC_IDX_IRQCLK);
  assign rd_data  = rd_ok & (idx == `USC_IDX_DATA);
  assign rd_rstat = rd_ok & (idx == `USC_IDX_RSTAT);

  // Frame format decode
  assign char_len  = {ctrl_rw_r[`USC_C_CHHI], ctrl_rw_r[`USC_C_CHLO]};
  assign nine_bits = char_len[1];
  assign loop_on   = (char_len == `USC_CH_LOOP);
  assign par_on    = ctrl_rw_r[`USC_C_PEN] & ~nine_bits;
  assign last_idx  = nbits - 4'h1;
  always_comb begin
    case (char_len)
      `USC_CH_7: nbits = `USC_N7;
      `USC_CH_8: nbits = `USC_N8;
      default:   nbits = `USC_N9;
    endcase
  end

  // Status views
  assign fault_any = ovr_r | frm_r | par_r | brk_r;
  assign rstat = {ovr_r, frm_r, par_r, brk_r, rx9_r, address_wait_mode_r, (tx_state_r != USC_TX_IDLE), lfault_r};
  always_comb begin
    case (idx)
      `USC_IDX_DATA:   rd_mux = rx_hold_r;
      `USC_IDX_BAUD:   rd_mux = baud_r;
      `USC_IDX_CTRL:   rd_mux = {ctrl_rw_r, fault_any, rx_full_r, tx_empty_r};
      `USC_IDX_RSTAT:  rd_mux = rstat;
      `USC_IDX_IRQCLK: rd_mux = irq_rw_r | {3'h0, sync_r, 4'h0};
      default:         rd_mux = `USC_REG_RST;
    endcase
  end

  // Handshake: waitrequest drops for exactly one cycle per access
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r  <= 1'b1;
      rdata_r <= {`USC_RD_PAD, `USC_REG_RST};
    end else if (take) begin
      wait_r  <= 1'b0;
      rdata_r <= {`USC_RD_PAD, rd_mux};
    end else begin
      wait_r  <= 1'b1;
    end
  end
  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;

  // Writable control fields; the mode bit is never written by software
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_rw_r <= `USC_CTRL_RW_RST;
      irq_rw_r  <= `USC_REG_RST;
      baud_r    <= `USC_REG_RST;
      tx_hold_r <= `USC_REG_RST;
    end else begin
      if (wr_ctrl) ctrl_rw_r <= avs_writedata_i[7:3];
      if (wr_irq)  irq_rw_r  <= avs_writedata_i[7:0] & `USC_IRQCLK_WMASK;
      if (wr_baud) baud_r    <= avs_writedata_i[7:0];
      if (wr_data) tx_hold_r <= avs_writedata_i[7:0];
    end
  end

  // Mode strap caught once after reset release, read-only afterwards
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_r <= 1'b0;
      sync_r       <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      sync_r       <= sync_mode_strap_i;
    end
  end

  // Internal baud level; divisor zero stops the clock
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      baud_cnt_r <= `USC_REG_RST;
      baud_lvl_r <= 1'b0;
      oe_n_r     <= 1'b1;
    end else begin
      oe_n_r <= ~clock_port_dir_out_i;
      if (baud_r == `USC_REG_RST) begin
        baud_cnt_r <= `USC_REG_RST;
      end else if (baud_cnt_r == baud_r) begin
        baud_cnt_r <= `USC_REG_RST;
        baud_lvl_r <= ~baud_lvl_r;
      end else begin
        baud_cnt_r <= baud_cnt_r + 8'h01;
      end
    end
  end
  assign serial_clock_pin_o      = baud_lvl_r;
  assign serial_clock_pin_oe_n_o = oe_n_r;

  // Clock source per direction
  usc_clk_sel u_tx_clk (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .ext_sel_i (irq_rw_r[`USC_I_XT]),
    .int_lvl_i (baud_lvl_r),
    .pin_lvl_i (serial_clock_pin_i),
    .rise_o    (tx_tick),
    .fall_o    ()
  );
  usc_clk_sel u_rx_clk (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .ext_sel_i (irq_rw_r[`USC_I_XR]),
    .int_lvl_i (baud_lvl_r),
    .pin_lvl_i (serial_clock_pin_i),
    .rise_o    (rx_rise),
    .fall_o    (rx_fall)
  );
  assign rx_tick = sync_r ? rx_fall : rx_rise;

  // Transmit sequencing terms
  assign tx_done  = tx_tick & (sync_r | (tx_cnt_r == `USC_OVS_LAST));
  assign stop_end = (tx_state_r == USC_TX_STOP) & tx_done & (~irq_rw_r[`USC_I_TWO_STOP_SELECT] | (tx_idx_r != 4'h0));
  assign tx_load  = ((tx_state_r == USC_TX_IDLE) | stop_end) & ~tx_empty_r & ~wr_data;
  assign tx_par   = usc_parity(tx_shift_r[7:0], (char_len == `USC_CH_7),
                               {ctrl_rw_r[`USC_C_PKHI], ctrl_rw_r[`USC_C_X9]});

  // Transmit frame state machine
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state_r <= USC_TX_IDLE;
      tx_cnt_r   <= 4'h0;
      tx_idx_r   <= 4'h0;
      tx_shift_r <= 9'h000;
    end else begin
      if (tx_tick) tx_cnt_r <= tx_cnt_r + 4'h1;
      case (tx_state_r)
        USC_TX_START: if (tx_done) begin
          tx_state_r <= USC_TX_DATA;
          tx_idx_r   <= 4'h0;
        end
        USC_TX_DATA: if (tx_done) begin
          tx_idx_r <= tx_idx_r + 4'h1;
          if (tx_idx_r == last_idx) begin
            tx_state_r <= par_on ? USC_TX_PAR : USC_TX_STOP;
            tx_idx_r   <= 4'h0;
          end
        end
        USC_TX_PAR: if (tx_done) begin
          tx_state_r <= USC_TX_STOP;
          tx_idx_r   <= 4'h0;
        end
        USC_TX_STOP: if (tx_done) begin
          tx_idx_r <= 4'h1;                                // Second stop bit
          if (stop_end) tx_state_r <= USC_TX_IDLE;
        end
        default: tx_state_r <= USC_TX_IDLE;
      endcase
      // Back-to-back frames start without an idle gap
      if (tx_load) begin
        tx_state_r <= USC_TX_START;
        tx_cnt_r   <= 4'h0;
        tx_shift_r <= {ctrl_rw_r[`USC_C_X9], tx_hold_r};
      end
    end
  end

  // Line level from the frame position
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_line_r <= 1'b1;
      tx_pin_r  <= 1'b1;
    end else begin
      case (tx_state_r)
        USC_TX_START: tx_line_r <= 1'b0;
        USC_TX_DATA:  tx_line_r <= tx_shift_r[tx_idx_r];
        USC_TX_PAR:   tx_line_r <= tx_par;
        default:      tx_line_r <= 1'b1;
      endcase
      // Break wins over data; disabled pin idles high
      tx_pin_r <= irq_rw_r[`USC_I_BRK] ? 1'b0 : (irq_rw_r[`USC_I_TXEN] ? tx_line_r : 1'b1);
    end
  end
  assign transmit_pin_o = tx_pin_r;

  // Transmit empty: load sets, data write clears; load never meets a write
  always_comb begin
    tx_empty_nxt = tx_empty_r;
    if (wr_data) tx_empty_nxt = 1'b0;
    if (tx_load) tx_empty_nxt = 1'b1;
  end

  // Receive input: pin wired direct, or looped from transmitter
  assign rx_in     = loop_on ? tx_line_r : receive_pin_i;
  assign rx_val    = sync_r ? rx_in : maj_r;
  assign rx_done   = rx_tick & (sync_r | (rx_cnt_r == `USC_OVS_LAST));
  assign frame_done = (rx_state_r == USC_RX_STOP) & rx_done;
  assign frm_set   = frame_done & ~rx_val;
  assign brk_set   = frame_done & ~rx_val & zero_r;
  assign par_set   = frame_done & par_on &
                     (rx_par_r != usc_parity(rx_shift_r[7:0], (char_len == `USC_CH_7),
                                             {ctrl_rw_r[`USC_C_PKHI], ctrl_rw_r[`USC_C_X9]}));
  // In attention mode with nine-bit frames only characters with ninth bit one are taken
  assign rx_accept = frame_done & (~address_wait_mode_r | ~nine_bits | rx_shift_r[8]);
  assign ovr_set   = rx_accept & rx_full_r & ~rd_data;
  assign rx_load   = rx_accept & ~ovr_set;

  // Receive frame state machine with centre sampling
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_state_r <= USC_RX_IDLE;
      rx_cnt_r   <= 4'h0;
      rx_idx_r   <= 4'h0;
      rx_shift_r <= 9'h000;
      s_r        <= 2'b00;
      maj_r      <= 1'b0;
      zero_r     <= 1'b0;
      rx_par_r   <= 1'b0;
    end else if (rx_tick) begin
      rx_cnt_r <= rx_cnt_r + 4'h1;
      if (rx_cnt_r == `USC_MID_A) s_r[0] <= rx_in;
      if (rx_cnt_r == `USC_MID_B) s_r[1] <= rx_in;
      if (rx_cnt_r == `USC_MID_C) maj_r  <= (s_r[0] & s_r[1]) | (s_r[0] & rx_in) | (s_r[1] & rx_in);
      case (rx_state_r)
        USC_RX_IDLE: if (!rx_in) begin
          rx_state_r <= sync_r ? USC_RX_DATA : USC_RX_START;
          rx_cnt_r   <= 4'h1;
          rx_idx_r   <= 4'h0;
          rx_shift_r <= 9'h000;
          zero_r     <= 1'b1;
        end
        USC_RX_START: begin
          // False start if the line is high again half a bit later
          if ((rx_cnt_r == `USC_MID_B) && rx_in) rx_state_r <= USC_RX_IDLE;
          else if (rx_done) rx_state_r <= USC_RX_DATA;
        end
        USC_RX_DATA: if (rx_done) begin
          rx_shift_r[rx_idx_r] <= rx_val;
          zero_r   <= zero_r & ~rx_val;
          rx_idx_r <= rx_idx_r + 4'h1;
          if (rx_idx_r == last_idx) rx_state_r <= par_on ? USC_RX_PAR : USC_RX_STOP;
        end
        USC_RX_PAR: if (rx_done) begin
          rx_par_r   <= rx_val;
          zero_r     <= zero_r & ~rx_val;
          rx_state_r <= USC_RX_STOP;
        end
        USC_RX_STOP: if (rx_done) rx_state_r <= USC_RX_IDLE; // One stop bit suffices
        default: rx_state_r <= USC_RX_IDLE;
      endcase
    end
  end

  // Receive buffer; an overrun keeps the older character
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_hold_r <= `USC_REG_RST;
      rx9_r     <= 1'b0;
    end else if (rx_load) begin
      rx_hold_r <= rx_shift_r[7:0];
      if (nine_bits) rx9_r <= rx_shift_r[8];
    end
  end

  // Receive full: load wins over a read in the same cycle
  always_comb begin
    rx_full_nxt = rx_full_r;
    if (rd_data) rx_full_nxt = 1'b0;
    if (rx_load) rx_full_nxt = 1'b1;
  end

  // Buffer flags and interrupt levels from next values, so pending tracks exactly
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_empty_r <= `USC_TXE_RST;
      rx_full_r  <= 1'b0;
      tx_irq_r   <= 1'b0;
      rx_irq_r   <= 1'b0;
    end else begin
      tx_empty_r <= tx_empty_nxt;
      rx_full_r  <= rx_full_nxt;
      tx_irq_r   <= tx_empty_nxt & (wr_irq ? avs_writedata_i[`USC_I_ETI] : irq_rw_r[`USC_I_ETI]);
      rx_irq_r   <= rx_full_nxt & (wr_irq ? avs_writedata_i[`USC_I_ERI] : irq_rw_r[`USC_I_ERI]);
    end
  end
  assign tx_irq_o = tx_irq_r;
  assign rx_irq_o = rx_irq_r;

  // Sticky errors; a read clears only bits it returned, new events win
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovr_r <= 1'b0;
      frm_r <= 1'b0;
      par_r <= 1'b0;
      brk_r <= 1'b0;
    end else begin
      ovr_r <= (ovr_r & ~(rd_rstat & rdata_r[`USC_S_OVR])) | ovr_set;
      frm_r <= (frm_r & ~(rd_rstat & rdata_r[`USC_S_FRM])) | frm_set;
      par_r <= (par_r & ~(rd_rstat & rdata_r[`USC_S_PAR])) | par_set;
      brk_r <= (brk_r & ~(rd_rstat & rdata_r[`USC_S_BRK])) | brk_set;
    end
  end

  // Attention bit and line fault
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      address_wait_mode_r   <= 1'b0;
      lfault_r <= 1'b0;
    end else begin
      if (wr_rstat) address_wait_mode_r <= avs_writedata_i[`USC_S_ADDRESS_WAIT_MODE];
      else if (frame_done && nine_bits && rx_shift_r[8]) address_wait_mode_r <= 1'b0;
      if (frm_set || brk_set) lfault_r <= 1'b1;
      else if ((rx_state_r == USC_RX_IDLE) && rx_in) lfault_r <= 1'b0;
    end
  end

  property p_txe_clr;
    wr_data |=> !tx_empty_r;
  endproperty
  a_txe_clr: assert property (p_txe_clr) else $error("tx empty not cleared by write");
  property p_txe_set;
    tx_load |=> tx_empty_r && (tx_state_r == USC_TX_START);
  endproperty
  a_txe_set: assert property (p_txe_set) else $error("tx empty not set on transfer");
  property p_rxf_clr;
    (rd_data && !rx_load) |=> !rx_full_r ##1 !rx_full_r || $rose(rx_full_r);
  endproperty
  a_rxf_clr: assert property (p_rxf_clr) else $error("rx full not cleared by read");
  property p_irq_tx;
    tx_irq_o == (tx_empty_r & irq_rw_r[`USC_I_ETI]);
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx interrupt level wrong");
  property p_irq_rx;
    rx_irq_o == (rx_full_r & irq_rw_r[`USC_I_ERI]);
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx interrupt level wrong");
  property p_fault;
    (ovr_set || frm_set || par_set || brk_set) |=> fault_any;
  endproperty
  a_fault: assert property (p_fault) else $error("global fault missing");
  property p_brk;
    irq_rw_r[`USC_I_BRK] |=> !transmit_pin_o;
  endproperty
  a_brk: assert property (p_brk) else $error("break not driving pin low");
  property p_act_end;
    (stop_end && !tx_load) |=> (tx_state_r == USC_TX_IDLE) ##1 tx_line_r;
  endproperty
  a_act_end: assert property (p_act_end) else $error("transmit active not ended");
  property p_address_wait_mode;
    (frame_done && nine_bits && rx_shift_r[8] && !wr_rstat) |=> !address_wait_mode_r;
  endproperty
  a_address_wait_mode: assert property (p_address_wait_mode) else $error("attention not cleared");
  property p_ovr_keep;
    ovr_set |=> ovr_r && $stable(rx_hold_r);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost old data");
  property p_lfault;
    (frm_set || brk_set) |=> lfault_r;
  endproperty
  a_lfault: assert property (p_lfault) else $error("line fault not raised");
  property p_nopar;
    (tx_state_r == USC_TX_DATA && tx_done && tx_idx_r == last_idx && !par_on) |=> tx_state_r != USC_TX_PAR;
  endproperty
  a_nopar: assert property (p_nopar) else $error("parity sent while disabled");

  c_tx_frame: cover property (stop_end ##1 tx_state_r == USC_TX_IDLE);
  c_rx_load:  cover property (rx_load ##1 rx_full_r);
  c_overrun:  cover property (ovr_set);
  c_b2b:      cover property (stop_end && tx_load);
endmodule

// *** tb/usc_peer.sv ***
// Purpose: Remote async transmitter driving the receive pin
// Assumes: Baud divisor 1, so a tick is four clocks
// Notes:   Line rests high between frames, as a pull-up would
`timescale 1ns/10ps
module usc_peer (
  input  wire logic clk_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  // Frame bits LSB first, sixteen ticks per bit
  task automatic send(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (64) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
endmodule

// *** tb/test_usart_control_status_regs.sv ***
// Purpose: Register and serial checks of the control block
// Assumes: Avalon master waits for waitrequest low
// Notes:   Transmit pin is checked for break and for the start bit
`timescale 1ns/10ps
`include "usc_defs.svh"
module test_usart_control_status_regs;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdata;
  logic        wreq, rx_pin, tx_pin, ck_o, ck_oe_n, rx_irq, tx_irq;
  logic        dir = 1'b1;
  int          failures = 0;
  int          num_checks = 0;
  usc_peer peer (.clk_i(clk_i), .line_o(rx_pin));
  usc_regs uut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .receive_pin_i(rx_pin), .transmit_pin_o(tx_pin), .serial_clock_pin_i(1'b0), .serial_clock_pin_o(ck_o),
    .serial_clock_pin_oe_n_o(ck_oe_n), .clock_port_dir_out_i(dir), .sync_mode_strap_i(1'b0),
    .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One bus access; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    adr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= {24'h000000, d};
    // No local limit: only the watchdog may end a stalled access
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrt(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, q);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard, well beyond the few thousand cycles of the run
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rc(`USC_IDX_CTRL, 8'h01);
    rc(`USC_IDX_RSTAT, 8'h00);
    rc(`USC_IDX_IRQCLK, 8'h00);
    rc(8'h10, 8'h00);
    chk({6'h00, ck_o, ck_oe_n}, 8'h00);
    wrt(`USC_IDX_IRQCLK, 8'hff);
    rc(`USC_IDX_IRQCLK, 8'hef);
    chk({7'h00, tx_pin}, 8'h00);
    wrt(`USC_IDX_IRQCLK, 8'h23); // Pin enabled so the start bit shows
    rc(`USC_IDX_RSTAT, 8'h00);
    chk({6'h00, rx_irq, tx_irq}, 8'h01);
    wrt(`USC_IDX_RSTAT, 8'h04);
    rc(`USC_IDX_RSTAT, 8'h04);
    wrt(`USC_IDX_RSTAT, 8'h00);
    wrt(`USC_IDX_BAUD, 8'h01);
    wrt(`USC_IDX_DATA, 8'ha5);
    rc(`USC_IDX_RSTAT, 8'h02);
    // Pin lags the frame state by two clocks
    repeat (2) @(posedge clk_i);
    chk({7'h00, tx_pin}, 8'h00);
    repeat (800) @(posedge clk_i);
    rc(`USC_IDX_RSTAT, 8'h00);
    // Single character, then buffer read clears full
    peer.send({1'b1, 8'h3c, 1'b0});
    repeat (60) @(posedge clk_i);
    rc(`USC_IDX_CTRL, 8'h03);
    chk({6'h00, rx_irq, tx_irq}, 8'h03);
    rc(`USC_IDX_DATA, 8'h3c);
    rc(`USC_IDX_CTRL, 8'h01);
    // Two characters unread: second one overruns
    peer.send({1'b1, 8'h11, 1'b0});
    peer.send({1'b1, 8'h22, 1'b0});
    repeat (60) @(posedge clk_i);
    rc(`USC_IDX_CTRL, 8'h07);
    rc(`USC_IDX_RSTAT, 8'h80);
    rc(`USC_IDX_RSTAT, 8'h00);
    rc(`USC_IDX_DATA, 8'h11);
    // Stop bit low gives a framing fault
    peer.send({1'b0, 8'hff, 1'b0});
    repeat (60) @(posedge clk_i);
    rc(`USC_IDX_RSTAT, 8'h40);
    rc(`USC_IDX_DATA, 8'hff);
    // All-zero frame: break plus framing fault
    peer.send(10'h000);
    repeat (60) @(posedge clk_i);
    rc(`USC_IDX_RSTAT, 8'h50);
    rc(`USC_IDX_DATA, 8'h00);
    // Seven bits with odd parity, parity bit sent wrong
    wrt(`USC_IDX_CTRL, 8'h88);
    peer.send({1'b1, 1'b0, 7'h41, 1'b0});
    repeat (60) @(posedge clk_i);
    rc(`USC_IDX_RSTAT, 8'h20);
    rc(`USC_IDX_DATA, 8'h41);
    // Loopback, nine bits; ninth bit one ends attention mode
    wrt(`USC_IDX_RSTAT, 8'h04);
    wrt(`USC_IDX_CTRL, 8'h38);
    wrt(`USC_IDX_DATA, 8'h5a);
    repeat (800) @(posedge clk_i);
    rc(`USC_IDX_RSTAT, 8'h08);
    rc(`USC_IDX_CTRL, 8'h3b);
    rc(`USC_IDX_DATA, 8'h5a);
    finish_test;
  end
endmodule
